/* sim/tof_checker.sv */
// Port assertions for the timed output queue
`timescale 1ns/1ps
`default_nettype none
module tof_checker #(parameter int DEPTH = 32) (
  input wire logic i_clk, i_resetn, i_entry_valid, i_rec_rd,
  input wire tof_pkg::tof_byte_t i_entry_sequence_number,
  input wire logic o_entry_ready, o_rec_ack, o_rec_valid, o_rec_last,
  input wire logic [1:0] o_do,
  input wire tof_pkg::tof_byte_t o_last_written_sequence, o_next_pending_sequence,
  input wire tof_pkg::tof_byte_t o_queue_status, o_queued_entry_count,
  input wire logic [31:0] o_us_ticker
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  ready_full_a: assert property (o_entry_ready == (o_queued_entry_count < DEPTH))
    else $error("ready disagrees with count");
  seq_capture_a: assert property (i_entry_valid && o_entry_ready |=>
    o_last_written_sequence == $past(i_entry_sequence_number)) else $error("seq lost");
  // A simultaneous write would hide the decrement, so skip those cycles
  issue_delete_a: assert property ($changed(o_do) && !$past(i_entry_valid) |->
    o_queued_entry_count == $past(o_queued_entry_count) - 8'h01) else $error("no delete");
  next_flag_a: assert property (o_queue_status[1] |-> o_next_pending_sequence[7])
    else $error("next flag");
  tick_hold_a: assert property ($changed(o_us_ticker) |=> $stable(o_us_ticker) [*8])
    else $error("ticker too fast");
  ack_valid_a: assert property (o_rec_ack |=> o_rec_valid) else $error("no record");
  busy_refuse_a: assert property (o_rec_valid |-> !o_rec_ack) else $error("ack busy");
  last_drop_a: assert property (o_rec_valid && o_rec_last && i_rec_rd |=> !o_rec_valid)
    else $error("record overrun");
endmodule : tof_checker
bind tof_queue tof_checker #(.DEPTH(DEPTH)) chk_u (.*);
`default_nettype wire

/* sim/tof_host.sv */
// Controller model writing one short batch of timed entries
`timescale 1ns/1ps
`default_nettype none
module tof_host (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_img,
  output logic [7:0] o_seq,
  output logic [15:0] o_us
);
  // Third entry has no enables, so it must not move the pins
  logic [7:0] img [3] = '{8'hB0, 8'h70, 8'hC0};
  int n = 0;
  always @(posedge i_clk) begin
    if (o_valid && i_ready) n <= n + 1;
  end
  assign o_valid = i_go && n < 3;
  assign o_img = (n < 3) ? img[n] : ~img[2]; // Released bus shows inverse
  assign o_seq = (n == 2) ? 8'h43 : 8'h01 + n[7:0];
  assign o_us = 16'd5 + 16'd4 * n[15:0];
endmodule : tof_host
`default_nettype wire

/* sim/tof_queue_tb_top.sv */
// Bench for the timed output queue
`timescale 1ns/1ps
`default_nettype none
module tof_queue_tb_top;
  import tof_pkg::*;
  logic i_clk = 0, i_resetn = 0, go = 0, i_entry_valid, i_rec_req = 0, i_rec_rd = 0;
  logic o_entry_ready, o_rec_ack, o_rec_valid, o_rec_last;
  tof_byte_t i_process_output_image, i_entry_sequence_number, i_record_number = 0;
  tof_byte_t o_last_written_sequence, o_next_pending_sequence, o_queue_status;
  tof_byte_t o_queued_entry_count, o_rec_data;
  logic [15:0] i_entry_time_us;
  logic [1:0] o_do;
  logic [31:0] o_us_ticker, snap;
  int errors = 0, cmp_count = 0, cyc = 0;
  tof_queue dut_u (.i_clk, .i_resetn, .i_entry_valid, .i_process_output_image,
    .i_entry_sequence_number, .i_entry_time_us, .o_entry_ready, .o_do,
    .o_last_written_sequence, .o_next_pending_sequence, .o_queue_status,
    .o_queued_entry_count, .o_us_ticker, .i_rec_req, .i_record_number, .i_rec_rd,
    .o_rec_ack, .o_rec_valid, .o_rec_data, .o_rec_last);
  tof_host host_u (.i_clk, .i_go(go), .i_ready(o_entry_ready), .o_valid(i_entry_valid),
    .o_img(i_process_output_image), .o_seq(i_entry_sequence_number), .o_us(i_entry_time_us));
  initial forever #25 i_clk = ~i_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Bounded wait for the queue to reach a fill level
  task automatic wt(tof_byte_t c);
    for (int k = 0; k < 1000 && o_queued_entry_count !== c; k++) begin
      @(posedge i_clk);
      #1;
    end
  endtask : wt
  task automatic t_queue;
    go = 1;
    wt(8'h03);
    chk("lastseq", 8'h43, o_last_written_sequence);
    chk("lastflag", 1, o_queue_status[7]);
    wt(8'h02);
    chk("issue1_us", 32'd5, o_us_ticker);
    chk("do1", 2'b01, o_do);
    chk("active", 1, o_queue_status[1]);
    wt(8'h01);
    chk("issue2_us", 32'd9, o_us_ticker);
    chk("do2", 2'b10, o_do);
    wt(8'h00);
    chk("do", 2'b10, o_do);
    chk("nextseq", 8'hC3, o_next_pending_sequence);
  endtask : t_queue
  // Request a record and read it byte by byte
  task automatic t_rec(tof_byte_t num, int len);
    logic [7:0] e;
    @(posedge i_clk);
    #1 i_record_number = num;
    i_rec_req = 1;
    snap = o_us_ticker;
    #1 chk("ack", 1, o_rec_ack);
    @(posedge i_clk);
    #1 i_rec_req = 0;
    for (int i = 0; i < len; i++) begin
      e = i == 1 ? 8'h1F : i == 4 ? 8'h72 : i == 6 ? 8'h02 : 8'h00;
      if (i > 15) e = snap[8*(i-16)+:8];
      chk("byte", e, o_rec_data);
      chk("last", i == len - 1, o_rec_last);
      i_rec_rd = 1;
      @(posedge i_clk);
      #1;
    end
    i_rec_rd = 0;
    chk("done", 0, o_rec_valid);
    i_record_number = 8'h02;
    i_rec_req = 1;
    #1 chk("badnum", 0, o_rec_ack);
    @(posedge i_clk);
    #1 i_rec_req = 0;
  endtask : t_rec
  task automatic conclude;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // Cycle ceiling well above the longest issue time
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_resetn = 1;
    t_queue();
    t_rec(8'h01, 20);
    t_rec(8'h00, 4);
    conclude();
  end
endmodule : tof_queue_tb_top
`default_nettype wire

/* src/tof_defs.svh */
// Constants for the timed output queue and its diagnostic record
`ifndef TOF_DEFS_SVH
`define TOF_DEFS_SVH
`define TOF_REC_SHORT 8'h00
`define TOF_REC_FULL 8'h01
`define TOF_REC_LEN_FULL 5'd20
`define TOF_REC_LEN_SHORT 5'd4
`define TOF_MODINFO 8'h1F
`define TOF_CHKIND 8'h72
`define TOF_DIAG_BITS 8'h00
`define TOF_CH_COUNT 8'h02
`define TOF_ERR_NONE 8'h00
`define TOF_LAST_BIT 6
`define TOF_NEXT_VALID_BIT 7
`define TOF_ST_LAST_SEEN 8'h80
`define TOF_ST_ACTIVE 8'h02
`define TOF_ST_FULL 8'h01
`define TOF_BYTE_SNAP 5'd16
`define TOF_US_NS 1000
`define TOF_CLK_NS 50
`define TOF_US_CYCLES (`TOF_US_NS / `TOF_CLK_NS)
`endif

/* src/tof_pkg.sv */
// Types for the timed output queue
package tof_pkg;
  typedef enum logic [1:0] {TOF_IDLE, TOF_WAIT, TOF_ISSUE} tof_state_t;
  typedef logic [7:0] tof_byte_t;
endpackage : tof_pkg

/* src/tof_queue.sv */
// Timestamp-scheduled two-channel output queue with diagnostic record
`timescale 1ns/1ps
`default_nettype none
`include "tof_defs.svh"
// How it works
// - Written entries enter the queue in order
// - Issue entries in order, then delete each
// - No interrupt; diagnostics only readable record
// - Record 01h full, record 00h four bytes
// - Module information byte reads 1Fh
// - Channel type 72h, bit 7 zero
// - Diagnostic bits per channel read 00h
// - Channel count byte reads 02h
// - Full record 01h carries ticker captured at request; 00h does not
module tof_queue #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_entry_valid,
  input wire tof_pkg::tof_byte_t i_process_output_image,
  input wire tof_pkg::tof_byte_t i_entry_sequence_number,
  input wire logic [15:0] i_entry_time_us,
  output logic o_entry_ready,
  output logic [1:0] o_do,
  output tof_pkg::tof_byte_t o_last_written_sequence,
  output tof_pkg::tof_byte_t o_next_pending_sequence,
  output tof_pkg::tof_byte_t o_queue_status,
  output tof_pkg::tof_byte_t o_queued_entry_count,
  output logic [31:0] o_us_ticker,
  input wire logic i_rec_req,
  input wire tof_pkg::tof_byte_t i_record_number,
  input wire logic i_rec_rd,
  output logic o_rec_ack,
  output logic o_rec_valid,
  output tof_pkg::tof_byte_t o_rec_data,
  output logic o_rec_last
);
  import tof_pkg::*;

  // Queue storage: outputs byte, sequence, time stamp
  tof_byte_t img_q [DEPTH];
  tof_byte_t seq_q [DEPTH];
  logic [15:0] ts_q [DEPTH];
  tof_byte_t img_d [DEPTH];
  tof_byte_t seq_d [DEPTH];
  logic [15:0] ts_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  tof_byte_t last_q, last_d, next_q, next_d, stat_q, stat_d;
  logic [1:0] do_q;
  logic [4:0] pre_q, pre_d;
  logic [31:0] us_q, us_d;
  tof_state_t st_q, st_d;
  logic push, pop, due;

  // Record state
  logic [31:0] snap_q, snap_d;
  logic [4:0] idx_q, idx_d, len_q, len_d;
  logic act_q, act_d;
  tof_byte_t rb;

  assign o_entry_ready = (cnt_q != DEPTH[AW:0]);
  assign push = i_entry_valid && o_entry_ready;
  // Only the low 16 ticker bits compare; stamps wrap at 65535 us
  assign due = (cnt_q != '0) && (us_q[15:0] == ts_q[rd_q]);
  assign pop = (st_q == TOF_ISSUE);

  // Free-running microsecond ticker from a 20-cycle prescaler
  always_comb begin
    pre_d = pre_q + 5'd1;
    us_d = us_q;
    if (pre_q == 5'(`TOF_US_CYCLES - 1)) begin
      pre_d = '0;
      us_d = us_q + 32'd1;
    end
  end

  // Ticker registers; the count restarts at reset, so stamps are
  // relative to the release of reset and the host must plan for that
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_q <= '0;
      us_q <= '0;
    end else begin
      pre_q <= pre_d;
      us_q <= us_d;
    end
  end

  // Issue sequencer: one entry per match, in queue order
  always_comb begin
    st_d = st_q;
    case (st_q)
      TOF_IDLE: if (cnt_q != '0) st_d = TOF_WAIT;
      TOF_WAIT: if (due) st_d = TOF_ISSUE;
      TOF_ISSUE: st_d = TOF_IDLE;
      default: st_d = TOF_IDLE;
    endcase
  end

  // Sequencer state; the idle pass costs a cycle but keeps issues apart
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= TOF_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Queue pointers, count, sequence outputs and status bytes
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    last_d = last_q;
    next_d = next_q;
    stat_d = stat_q;
    if (push) begin
      wr_d = wr_q + AW'(1);
      last_d = i_entry_sequence_number;
      if (i_entry_sequence_number[`TOF_LAST_BIT]) begin
        stat_d = stat_q | `TOF_ST_LAST_SEEN;
      end
    end
    if (pop) begin
      next_d = seq_q[rd_q] | (8'h01 << `TOF_NEXT_VALID_BIT);
      stat_d = stat_d | `TOF_ST_ACTIVE;
      rd_d = rd_q + AW'(1);
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    stat_d[0] = (cnt_d == DEPTH[AW:0]);
  end

  // Queue pointer and status registers
  // Sticky status bits are only ever set; reset is the one way to clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      last_q <= '0;
      next_q <= '0;
      stat_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      next_q <= next_d;
      stat_q <= stat_d;
    end
  end

  // Entry storage, one slot per generate pass
  // Slots clear to zero at reset; due needs a nonzero count, so a stale stamp never issues
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_comb begin
      img_d[e] = img_q[e];
      seq_d[e] = seq_q[e];
      ts_d[e] = ts_q[e];
      if (push && (wr_q == AW'(e))) begin
        img_d[e] = i_process_output_image;
        seq_d[e] = i_entry_sequence_number;
        ts_d[e] = i_entry_time_us;
      end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        img_q[e] <= '0;
        seq_q[e] <= '0;
        ts_q[e] <= '0;
      end else begin
        img_q[e] <= img_d[e];
        seq_q[e] <= seq_d[e];
        ts_q[e] <= ts_d[e];
      end
    end
  end

  // Per-channel output latch; a channel without its enable keeps its level
  // Bit 7 and 5 serve the first channel, bit 6 and 4 the second
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic bit_q, bit_d;
    always_comb begin
      bit_d = bit_q;
      if (pop && img_q[rd_q][5-c]) begin
        bit_d = img_q[rd_q][7-c];
      end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        bit_q <= 1'b0;
      end else begin
        bit_q <= bit_d;
      end
    end
    assign do_q[c] = bit_q;
  end

  // Record reader; snapshot taken when request is accepted
  always_comb begin
    snap_d = snap_q;
    idx_d = idx_q;
    len_d = len_q;
    act_d = act_q;
    o_rec_ack = 1'b0;
    if (i_rec_req && !act_q) begin
      if (i_record_number == `TOF_REC_FULL || i_record_number == `TOF_REC_SHORT) begin
        o_rec_ack = 1'b1;
        act_d = 1'b1;
        idx_d = '0;
        snap_d = us_q;
        len_d = (i_record_number == `TOF_REC_FULL) ? `TOF_REC_LEN_FULL
                                                   : `TOF_REC_LEN_SHORT;
      end
    end else if (act_q && i_rec_rd) begin
      idx_d = idx_q + 5'd1;
      if (idx_q == len_q - 5'd1) act_d = 1'b0;
    end
  end

  // Record registers; diagnostics are only read out, never signalled
  // A request during a readout is refused rather than queued
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      snap_q <= '0;
      idx_q <= '0;
      len_q <= '0;
      act_q <= 1'b0;
    end else begin
      snap_q <= snap_d;
      idx_q <= idx_d;
      len_q <= len_d;
      act_q <= act_d;
    end
  end

  // Record byte map; error bytes fixed at zero
  // Index past the full record's end reads zero, so an idle port never shows unknowns
  always_comb begin
    rb = `TOF_ERR_NONE;
    if (idx_q == 5'd0) begin
      rb = `TOF_ERR_NONE;
    end else if (idx_q == 5'd1) begin
      rb = `TOF_MODINFO;
    end else if (idx_q == 5'd2 || idx_q == 5'd3) begin
      rb = `TOF_ERR_NONE;
    end else if (idx_q == 5'd4) begin
      rb = `TOF_CHKIND & 8'h7F;
    end else if (idx_q == 5'd5) begin
      rb = `TOF_DIAG_BITS;
    end else if (idx_q == 5'd6) begin
      rb = `TOF_CH_COUNT;
    end else if (idx_q < `TOF_BYTE_SNAP) begin
      rb = `TOF_ERR_NONE;
    end else if (idx_q < `TOF_REC_LEN_FULL) begin
      rb = snap_q[8*(idx_q-`TOF_BYTE_SNAP) +: 8];
    end
  end

  // No interrupt output exists; every status is polled by the host

  // Output drive
  assign o_do = do_q;
  assign o_last_written_sequence = last_q;
  assign o_next_pending_sequence = next_q;
  assign o_queue_status = stat_q;
  assign o_queued_entry_count = 8'(cnt_q);
  assign o_us_ticker = us_q;
  assign o_rec_valid = act_q;
  assign o_rec_data = rb;
  assign o_rec_last = act_q && (idx_q == len_q - 5'd1);
endmodule : tof_queue
`default_nettype wire
